// file: shared/omr_pkg.sv
// package: operating mode register constants and types
package omr_pkg;
	localparam logic [7:0] OMR_RESET = 8'h80;
	localparam int OMR_FMT_BIT = 7;
	localparam int OMR_BAUD_BIT = 6;
	localparam int OMR_FLOW_BIT = 5;
	localparam int OMR_ECHO_BIT = 4;
	localparam int OMR_PKIND_BIT = 2;
	localparam int OMR_SKIND_BIT = 1;
	localparam int OMR_PORT_BIT = 0;
	localparam logic [3:0] OMR_BAUD_RESET = 4'h0;
	localparam logic [3:0] OMR_BAUD_ADAPT = 4'h8;
	localparam logic [1:0] OMR_CR_NEEDED = 2'h2;
	localparam logic [7:0] OMR_CR_CHAR = 8'h0D;
	localparam int OMR_XTAL_HZ = 11000000;
	localparam int OMR_CLK_HZ = 50000000;

	typedef enum logic [1:0] {
		OMR_DST_SERIAL = 2'h0,
		OMR_DST_LCD = 2'h1,
		OMR_DST_PAR = 2'h3,
		OMR_DST_LED = 2'h2
	} omr_dest_t;

	typedef struct packed {
		logic command_format_select;
		logic flow_control_enable;
		logic position_echo_enable;
		logic parallel_display_kind;
		logic serial_display_kind;
		logic display_port_select;
	} omr_mode_t;
endpackage

// file: hdl/omr_mode_reg.sv
// operating mode register with baud select and output steering
`timescale 1ns/100ps
// Behaviour
// - register reachable only through the set-mode command
// - power-up value 0x80
// - format bit one means ascii parsing, zero binary
// - echo bit makes position output on each jog or home step
// - port bit picks serial (0) or parallel (1) output destination
// - serial kind bit picks plain or lcd-formatted serial output
// - parallel kind zero: handshake output, pending flag low while waiting if flow bit clear
// - parallel kind one: led display, select strobe during writes
// - flow bit turns user bit 6 into active-low clear-to-send
// - clear-to-send low when ready, high while busy
// - clear-to-send never busy during jog stepping
// - baud-set bit: low nibble sets rate, byte not stored
// - codes 0-7 fixed rates, 8 adaptive, 9-F undefined
// - fixed rates scale with crystal; adaptive compensates (here only the 4-bit code is stored, OMR_XTAL_HZ is unused)
// - rate applied at command, persists until reset or next baud set
// - after adaptive select, no transmit until two carriage returns
module omr_mode_reg
	import omr_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// set-mode command from the command parser
	input wire logic mode_wr,
	input wire logic [7:0] mode_byte,
	// device activity
	input wire logic busy,
	input wire logic jog_active,
	input wire logic home_active,
	input wire logic step_pulse,
	input wire logic out_pending,
	input wire logic led_write,
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	input wire logic user_bit_6_gp,
	input wire logic user_bit_7_gp,
	// decoded mode
	output logic [7:0] mode_q,
	output logic ascii_mode_q,
	output logic echo_req_q,
	output logic [1:0] dest_q,
	output logic [3:0] baud_code_q,
	output logic baud_valid_q,
	output logic tx_enable_q,
	// shared pins
	output logic user_bit_6_q,
	output logic user_bit_7_q
);
	logic [1:0] cr_cnt_q;
	logic [1:0] cr_cnt_d;
	logic [7:0] mode_d;
	logic [3:0] baud_d;
	logic adapt_wait_d;
	logic adapt_wait_q;
	logic baud_sel;
	logic [1:0] dest_d;
	logic ub6_d;
	logic ub7_d;
	logic cts_busy;

	function automatic logic [1:0] dest_of(input logic [7:0] m);
		if (!m[OMR_PORT_BIT])
			dest_of = m[OMR_SKIND_BIT] ? OMR_DST_LCD : OMR_DST_SERIAL;
		else
			dest_of = m[OMR_PKIND_BIT] ? OMR_DST_LED : OMR_DST_PAR;
	endfunction

	assign baud_sel = mode_wr && mode_byte[OMR_BAUD_BIT];
	// whole byte replaces register unless it is a baud set
	assign mode_d = (mode_wr && !baud_sel) ? mode_byte : mode_q;
	assign baud_d = baud_sel ? mode_byte[3:0] : baud_code_q;
	// only the code is kept; nothing here scales it with the crystal
	assign adapt_wait_d = baud_sel ? (mode_byte[3:0] == OMR_BAUD_ADAPT) :
		(adapt_wait_q && !(cr_cnt_d == OMR_CR_NEEDED));
	assign cr_cnt_d = baud_sel ? 2'h0 :
		(adapt_wait_q && rx_valid && rx_char == OMR_CR_CHAR) ?
		2'(cr_cnt_q + 2'h1) : cr_cnt_q;
	assign dest_d = dest_of(mode_d);
	assign cts_busy = busy && !jog_active;
	assign ub6_d = mode_d[OMR_FLOW_BIT] ? cts_busy :
		(dest_d == OMR_DST_PAR) ? !out_pending :
		user_bit_6_gp;
	assign ub7_d = (dest_d == OMR_DST_LED) ? led_write :
		user_bit_7_gp;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= OMR_RESET;
			baud_code_q <= OMR_BAUD_RESET;
			adapt_wait_q <= 1'b0;
			cr_cnt_q <= 2'h0;
			ascii_mode_q <= 1'b1;
			echo_req_q <= 1'b0;
			dest_q <= OMR_DST_SERIAL;
			baud_valid_q <= 1'b1;
			tx_enable_q <= 1'b1;
			user_bit_6_q <= 1'b1;
			user_bit_7_q <= 1'b1;
		end else begin
			mode_q <= mode_d;
			baud_code_q <= baud_d;
			adapt_wait_q <= adapt_wait_d;
			cr_cnt_q <= adapt_wait_d ? cr_cnt_d : 2'h0;
			ascii_mode_q <= mode_d[OMR_FMT_BIT];
			echo_req_q <= mode_d[OMR_ECHO_BIT] && step_pulse &&
				(jog_active || home_active);
			dest_q <= dest_d;
			baud_valid_q <= !baud_d[3] || (baud_d == OMR_BAUD_ADAPT);
			tx_enable_q <= !adapt_wait_d;
			user_bit_6_q <= ub6_d;
			user_bit_7_q <= ub7_d;
		end
	end

	property p_full_write;
		@(posedge mclk) disable iff (!resetn)
		mode_wr && !mode_byte[OMR_BAUD_BIT] |=> mode_q == $past(mode_byte);
	endproperty
	a_full_write: assert property (p_full_write)
		else $error("mode byte not stored");

	property p_baud_keeps;
		@(posedge mclk) disable iff (!resetn)
		baud_sel |=> $stable(mode_q) && baud_code_q == $past(mode_byte[3:0]);
	endproperty
	a_baud_keeps: assert property (p_baud_keeps)
		else $error("baud set disturbed mode");

	property p_fmt;
		@(posedge mclk) disable iff (!resetn)
		ascii_mode_q == mode_q[OMR_FMT_BIT];
	endproperty
	a_fmt: assert property (p_fmt)
		else $error("format mismatch");

	property p_cts;
		@(posedge mclk) disable iff (!resetn)
		mode_d[OMR_FLOW_BIT] |=> user_bit_6_q == $past(busy && !jog_active);
	endproperty
	a_cts: assert property (p_cts)
		else $error("clear-to-send wrong");

	property p_jog_cts;
		@(posedge mclk) disable iff (!resetn)
		mode_d[OMR_FLOW_BIT] && jog_active |=> !user_bit_6_q;
	endproperty
	a_jog_cts: assert property (p_jog_cts)
		else $error("busy during jog");

	property p_led;
		@(posedge mclk) disable iff (!resetn)
		dest_d == OMR_DST_LED |=> user_bit_7_q == $past(led_write);
	endproperty
	a_led: assert property (p_led)
		else $error("led select wrong");

	property p_adapt;
		@(posedge mclk) disable iff (!resetn)
		baud_sel && mode_byte[3:0] == OMR_BAUD_ADAPT |=> !tx_enable_q;
	endproperty
	a_adapt: assert property (p_adapt)
		else $error("transmit before rate known");

	property p_echo;
		@(posedge mclk) disable iff (!resetn)
		echo_req_q |-> $past(mode_q[OMR_ECHO_BIT] || mode_d[OMR_ECHO_BIT]);
	endproperty
	a_echo: assert property (p_echo)
		else $error("echo without enable");

	// adaptive wait, no carriage return this cycle
	sequence s_cr_wait;
		adapt_wait_q && !baud_sel && !(rx_valid && rx_char == OMR_CR_CHAR);
	endsequence

	sequence s_first_cr;
		adapt_wait_q && !baud_sel && cr_cnt_q == 2'h0 && rx_valid &&
			rx_char == OMR_CR_CHAR;
	endsequence

	sequence s_last_cr;
		adapt_wait_q && !baud_sel && cr_cnt_q == 2'h1 && rx_valid &&
			rx_char == OMR_CR_CHAR;
	endsequence

	property p_adapt_hold;
		@(posedge mclk) disable iff (!resetn)
		s_cr_wait |=> !tx_enable_q;
	endproperty
	a_adapt_hold: assert property (p_adapt_hold)
		else $error("transmit enabled without carriage returns");

	property p_first_cr;
		@(posedge mclk) disable iff (!resetn)
		s_first_cr |=> !tx_enable_q && cr_cnt_q == 2'h1;
	endproperty
	a_first_cr: assert property (p_first_cr)
		else $error("one carriage return ended the wait");

	property p_last_cr;
		@(posedge mclk) disable iff (!resetn)
		s_last_cr |=> tx_enable_q;
	endproperty
	a_last_cr: assert property (p_last_cr)
		else $error("second carriage return did not end the wait");

	property p_tx_fixed;
		@(posedge mclk) disable iff (!resetn)
		baud_sel && mode_byte[3:0] != OMR_BAUD_ADAPT |=> tx_enable_q;
	endproperty
	a_tx_fixed: assert property (p_tx_fixed)
		else $error("fixed rate blocked transmit");

	property p_baud_hold;
		@(posedge mclk) disable iff (!resetn)
		!baud_sel |=> $stable(baud_code_q);
	endproperty
	a_baud_hold: assert property (p_baud_hold)
		else $error("rate changed without baud set");

	property p_mode_hold;
		@(posedge mclk) disable iff (!resetn)
		!mode_wr |=> $stable(mode_q);
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("mode changed without command");

	property p_bin;
		@(posedge mclk) disable iff (!resetn)
		mode_wr && !mode_byte[OMR_BAUD_BIT] && !mode_byte[OMR_FMT_BIT]
			|=> !ascii_mode_q;
	endproperty
	a_bin: assert property (p_bin)
		else $error("binary format not taken");

	property p_valid_fixed;
		@(posedge mclk) disable iff (!resetn)
		!baud_code_q[3] |-> baud_valid_q;
	endproperty
	a_valid_fixed: assert property (p_valid_fixed)
		else $error("fixed code marked invalid");

	property p_valid_adapt;
		@(posedge mclk) disable iff (!resetn)
		baud_code_q == OMR_BAUD_ADAPT |-> baud_valid_q;
	endproperty
	a_valid_adapt: assert property (p_valid_adapt)
		else $error("adaptive code marked invalid");

	property p_valid_undef;
		@(posedge mclk) disable iff (!resetn)
		baud_code_q[3] && baud_code_q != OMR_BAUD_ADAPT |-> !baud_valid_q;
	endproperty
	a_valid_undef: assert property (p_valid_undef)
		else $error("undefined code marked valid");

	property p_dest_ser;
		@(posedge mclk) disable iff (!resetn)
		!mode_q[OMR_PORT_BIT] |-> !dest_q[1];
	endproperty
	a_dest_ser: assert property (p_dest_ser)
		else $error("serial port bit gave parallel output");

	property p_dest_par;
		@(posedge mclk) disable iff (!resetn)
		mode_q[OMR_PORT_BIT] |-> dest_q[1];
	endproperty
	a_dest_par: assert property (p_dest_par)
		else $error("parallel port bit gave serial output");

	property p_lcd;
		@(posedge mclk) disable iff (!resetn)
		!mode_q[OMR_PORT_BIT] |-> dest_q[0] == mode_q[OMR_SKIND_BIT];
	endproperty
	a_lcd: assert property (p_lcd)
		else $error("serial kind wrong");

	property p_led_kind;
		@(posedge mclk) disable iff (!resetn)
		mode_q[OMR_PORT_BIT] |->
			(dest_q == OMR_DST_LED) == mode_q[OMR_PKIND_BIT];
	endproperty
	a_led_kind: assert property (p_led_kind)
		else $error("parallel kind wrong");

	property p_pending;
		@(posedge mclk) disable iff (!resetn)
		!mode_d[OMR_FLOW_BIT] && dest_d == OMR_DST_PAR
			|=> user_bit_6_q == !$past(out_pending);
	endproperty
	a_pending: assert property (p_pending)
		else $error("pending flag wrong");

	property p_ub6_gp;
		@(posedge mclk) disable iff (!resetn)
		!mode_d[OMR_FLOW_BIT] && dest_d != OMR_DST_PAR
			|=> user_bit_6_q == $past(user_bit_6_gp);
	endproperty
	a_ub6_gp: assert property (p_ub6_gp)
		else $error("user bit 6 taken over");

	property p_ub7_gp;
		@(posedge mclk) disable iff (!resetn)
		dest_d != OMR_DST_LED |=> user_bit_7_q == $past(user_bit_7_gp);
	endproperty
	a_ub7_gp: assert property (p_ub7_gp)
		else $error("user bit 7 taken over");

	property p_cts_ready;
		@(posedge mclk) disable iff (!resetn)
		mode_d[OMR_FLOW_BIT] && !busy |=> !user_bit_6_q;
	endproperty
	a_cts_ready: assert property (p_cts_ready)
		else $error("clear-to-send busy while idle");

	property p_echo_on;
		@(posedge mclk) disable iff (!resetn)
		mode_d[OMR_ECHO_BIT] && step_pulse && (jog_active || home_active)
			|=> echo_req_q;
	endproperty
	a_echo_on: assert property (p_echo_on)
		else $error("step not echoed");

	property p_echo_idle;
		@(posedge mclk) disable iff (!resetn)
		!step_pulse |=> !echo_req_q;
	endproperty
	a_echo_idle: assert property (p_echo_idle)
		else $error("echo without step");
endmodule

// file: tb/omr_host_model.sv
// host model that issues whole set-mode bytes
`timescale 1ns/100ps
module omr_host_model (
	// clock
	input wire logic mclk,
	// set-mode command port
	output logic mode_wr,
	output logic [7:0] mode_byte
);
	initial begin
		mode_wr = 1'b0;
		mode_byte = 8'hA5;
	end
	// one whole byte per command, released to its inverse
	task send(input logic [7:0] b);
		mode_wr <= 1'b1;
		mode_byte <= b;
		@(negedge mclk);
		mode_wr <= 1'b0;
		mode_byte <= ~b;
	endtask
endmodule

// file: tb/omr_mode_reg_tb_top.sv
// self-checking bench for the operating mode register
`timescale 1ns/100ps
module omr_mode_reg_tb_top;
	import omr_pkg::*;
	logic mclk, resetn, mode_wr, busy, jog_active, out_pending, led_write;
	logic rx_valid, user_bit_6_gp, user_bit_7_gp, due, tx;
	logic home_active, step_pulse, echo_req_q, baud_valid_q;
	logic ascii_mode_q, tx_enable_q, user_bit_6_q, user_bit_7_q;
	logic [7:0] mode_byte, rx_char, m, mode_q;
	logic [3:0] bd, baud_code_q;
	logic [1:0] dest_q;
	logic [19:0] q[$];
	logic [7:0] dl[4] = '{8'h80, 8'h82, 8'h81, 8'h85};
	int bad_count, cmp_count, cyc, seed;
	omr_host_model host (.mclk, .mode_wr, .mode_byte);
	omr_mode_reg dut (.mclk, .resetn, .mode_wr, .mode_byte, .busy,
		.jog_active, .home_active, .step_pulse, .out_pending,
		.led_write, .rx_valid, .rx_char, .user_bit_6_gp, .user_bit_7_gp,
		.mode_q, .ascii_mode_q, .echo_req_q, .dest_q, .baud_code_q,
		.baud_valid_q, .tx_enable_q, .user_bit_6_q, .user_bit_7_q);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	function automatic logic [19:0] ex();
		logic [1:0] d;
		logic u;
		d = m[0] ? (m[2] ? OMR_DST_LED : OMR_DST_PAR)
			: (m[1] ? OMR_DST_LCD : OMR_DST_SERIAL);
		u = m[5] ? busy & ~jog_active
			: (d == OMR_DST_PAR ? ~out_pending : user_bit_6_gp);
		return {m, m[7], bd, tx, d, u,
			(d == OMR_DST_LED ? led_write : user_bit_7_gp),
			(!bd[3] || bd == OMR_BAUD_ADAPT),
			m[4] & step_pulse & (jog_active | home_active)};
	endfunction
	task chk(input logic [19:0] e, input logic [19:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] mode outputs exp %h got %h", e, g);
		end
	endtask
	always @(negedge mclk) if (due) begin
		chk(q.pop_front(), {mode_q, ascii_mode_q, baud_code_q, tx_enable_q,
			dest_q, user_bit_6_q, user_bit_7_q, baud_valid_q,
			echo_req_q});
		due <= 1'b0;
	end
	task step(input logic w, input logic [7:0] b);
		@(negedge mclk);
		if (w && b[6]) begin
			bd = b[3:0];
			tx = b[3:0] != OMR_BAUD_ADAPT;
		end else if (w) begin
			m = b;
		end
		q.push_back(ex());
		due <= 1'b1;
		if (w) host.send(b);
		else @(negedge mclk);
		@(negedge mclk);
	endtask
	task cr();
		@(negedge mclk);
		rx_valid = 1'b1;
		rx_char = OMR_CR_CHAR;
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_char = $random(seed);
	endtask
	task test_done();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		seed = 40103;
		{resetn, busy, jog_active, out_pending, led_write, rx_valid} = 6'h00;
		{user_bit_6_gp, user_bit_7_gp, due, tx} = 4'hD;
		rx_char = 8'h00;
		{home_active, step_pulse} = 2'h0;
		m = OMR_RESET;
		bd = OMR_BAUD_RESET;
		repeat (12) @(negedge mclk);
		resetn = 1'b1;
		step(0, 8'h00);
		busy = 1'b1;
		step(1, 8'h20);
		jog_active = 1'b1;
		step(0, 8'h00);
		step(1, 8'h45);
		{home_active, step_pulse} = 2'h3;
		step(1, 8'h90);
		{home_active, step_pulse} = 2'h0;
		for (int i = 0; i < 4; i++) begin
			out_pending = i[0];
			led_write = ~i[0];
			step(1, dl[i]);
		end
		step(1, 8'h48);
		cr();
		step(0, 8'h00);
		cr();
		tx = 1'b1;
		step(0, 8'h00);
		step(1, 8'h4A);
		repeat (8) begin
			{busy, jog_active, out_pending, led_write} = $random(seed);
			{user_bit_6_gp, user_bit_7_gp, home_active, step_pulse} =
				$random(seed);
			step(1, $random(seed) & 8'hB7);
		end
		@(negedge mclk);
		resetn = 1'b0;
		{m, bd, tx} = {OMR_RESET, OMR_BAUD_RESET, 1'b1};
		@(negedge mclk);
		resetn = 1'b1;
		step(0, 8'h00);
		test_done();
	end
endmodule
